// file: tx_dev_lock_pkg.sv
package tx_dev_lock_pkg;

  // ****************************************************************
  // Register map (index and byte address)
  // ****************************************************************
  localparam logic [7:0] DEV_IDX    = 8'h0E;
  localparam logic [7:0] LOCK_IDX   = 8'h15;
  localparam logic [7:0] ANA_IDX    = 8'h17;
  localparam logic [7:0] CLKDIV_IDX = 8'h20;
  localparam logic [7:0] STAT_IDX   = 8'h21;
  localparam logic [7:0] DEV_ADDR    = {DEV_IDX[5:0], 2'b00};
  localparam logic [7:0] LOCK_ADDR   = {LOCK_IDX[5:0], 2'b00};
  localparam logic [7:0] ANA_ADDR    = {ANA_IDX[5:0], 2'b00};
  localparam logic [7:0] CLKDIV_ADDR = {CLKDIV_IDX[5:0], 2'b00};
  localparam logic [7:0] STAT_ADDR   = {STAT_IDX[5:0], 2'b00};

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0]  DEV_RST     = 8'hE8;
  localparam logic [7:0]  LOCK_RST    = 8'h00;
  localparam logic [7:0]  ANA_RST     = 8'h83;
  localparam logic [7:0]  ANA_MASK    = 8'h9F;
  localparam logic [15:0] CLKDIV_RST  = 16'h0440;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GAUSS_BIT = 7;
  localparam int EXP_HI    = 6;
  localparam int EXP_LO    = 4;
  localparam int MANT_HI   = 3;
  localparam int MANT_LO   = 0;
  localparam int SEL_HI    = 7;
  localparam int SEL_LO    = 4;
  localparam int WIN_BIT   = 3;
  localparam int MODE_BIT  = 2;
  localparam int THR_HI    = 1;
  localparam int THR_LO    = 0;
  localparam int BAND_BIT  = 7;
  localparam int PDL_BIT   = 4;
  localparam int BOOST_BIT = 2;
  localparam int BIAS_HI   = 1;
  localparam int BIAS_LO   = 0;
  localparam int REFD_HI   = 7;
  localparam int REFD_LO   = 5;
  localparam int DIV2_HI   = 1;
  localparam int DIV2_LO   = 0;
  localparam int DIV1_HI   = 15;
  localparam int DIV1_LO   = 8;

  // ****************************************************************
  // Lock pin source codes
  // ****************************************************************
  localparam logic [3:0] SRC_ONE   = 4'h1;
  localparam logic [3:0] SRC_SUST  = 4'h2;
  localparam logic [3:0] SRC_MOM   = 4'h3;
  localparam logic [3:0] SRC_CAL   = 4'h5;
  localparam logic [3:0] SRC_XTAL  = 4'h7;
  localparam logic [3:0] SRC_REF   = 4'h8;
  localparam logic [3:0] SRC_PRE   = 4'hB;
  localparam logic [3:0] SRC_DS    = 4'hC;
  localparam logic [3:0] SRC_SYM   = 4'hD;
  localparam logic [3:0] SRC_OSC   = 4'hE;
  localparam logic [3:0] SRC_PHASE = 4'hF;

  // ****************************************************************
  // Deviation, window and divider constants
  // ****************************************************************
  localparam logic [4:0] SHIFT_LOW  = 5'h10;
  localparam logic [4:0] SHIFT_HIGH = 5'h0F;
  localparam logic [2:0] WIN_NARROW = 3'h2;
  localparam logic [2:0] WIN_WIDE   = 3'h4;
  localparam logic [2:0] GAP_MAX    = 3'h7;
  localparam logic [2:0] BAUD_LAST  = 3'h7;
  localparam logic [9:0] CNT_MAX    = 10'h3FF;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b01,
    MEAS_RUN  = 2'b10
  } meas_state_t;

  // Lock threshold per accuracy code
  function automatic logic [9:0] thr_lock(input logic [1:0] sel);
    case (sel)
      2'h0:    thr_lock = 10'h07F;
      2'h1:    thr_lock = 10'h0FF;
      2'h2:    thr_lock = 10'h1FF;
      default: thr_lock = 10'h3FF;
    endcase
  endfunction

  // Unlock threshold per accuracy code
  function automatic logic [9:0] thr_unlock(input logic [1:0] sel);
    case (sel)
      2'h0:    thr_unlock = 10'h06F;
      2'h1:    thr_unlock = 10'h0EF;
      2'h2:    thr_unlock = 10'h1EF;
      default: thr_unlock = 10'h3EF;
    endcase
  endfunction

endpackage

// file: tx_deviation_lock_config.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module tx_deviation_lock_config
  import tx_dev_lock_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        prescaler_clk_pin,
  input  wire logic        ref_cmp_pin,
  input  wire logic        div_cmp_pin,
  input  wire logic        ds_divider_clock_pin,
  input  wire logic        osc_cal_cmp_pin,
  input  wire logic        cal_done_pin,
  output logic             lock_pin,
  output logic             gauss_shape_en,
  output logic             ook_mode,
  output logic [10:0]      dev_scaled,
  output logic [4:0]       dev_shift,
  output logic             band_choice,
  output logic             detector_delay_long,
  output logic             amp_bias_extra,
  output logic [1:0]       divider_buffer_bias,
  output logic             ref_tick,
  output logic             symbol_tick,
  output logic             baud_tick
);

  // ****************************************************************
  // Register bus state
  // ****************************************************************
  logic [7:0]  dev_r, dev_nxt, lock_r, lock_nxt, ana_r, ana_nxt;
  logic [15:0] clkdiv_r, clkdiv_nxt;
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [31:0] wdat_r, wdat_nxt;
  logic [3:0]  wstb_r, wstb_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] status_word;

  // Lock detector state, declared early for status reads
  meas_state_t meas_r, meas_nxt;
  logic [2:0]  gap_r, gap_nxt;
  logic [9:0]  cnt_r, cnt_nxt;
  logic        locked_r, locked_nxt, mom_r, mom_nxt;
  logic        cmp_done, in_win;

  assign status_word = {6'h00, cnt_r, 14'h0000, mom_r, locked_r};

  // Write channel capture, register update and read answer
  always_comb begin
    dev_nxt     = dev_r;
    lock_nxt    = lock_r;
    ana_nxt     = ana_r;
    clkdiv_nxt  = clkdiv_r;
    aw_got_nxt  = aw_got_r | (awvalid & awready_r);
    w_got_nxt   = w_got_r | (wvalid & wready_r);
    waddr_nxt   = (awvalid & awready_r) ? awaddr : waddr_r;
    wdat_nxt    = (wvalid & wready_r) ? wdata : wdat_r;
    wstb_nxt    = (wvalid & wready_r) ? wstrb : wstb_r;
    bvalid_nxt  = bvalid_r & ~bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r & ~rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (aw_got_r && w_got_r && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      if (waddr_r[7:2] == DEV_ADDR[7:2]) begin
        if (wstb_r[0]) dev_nxt = wdat_r[7:0];
      end else if (waddr_r[7:2] == LOCK_ADDR[7:2]) begin
        if (wstb_r[0]) lock_nxt = wdat_r[7:0];
      end else if (waddr_r[7:2] == ANA_ADDR[7:2]) begin
        if (wstb_r[0]) ana_nxt = wdat_r[7:0] & ANA_MASK;
      end else if (waddr_r[7:2] == CLKDIV_ADDR[7:2]) begin
        if (wstb_r[0]) clkdiv_nxt[7:0] = wdat_r[7:0];
        if (wstb_r[1]) clkdiv_nxt[15:8] = wdat_r[15:8];
      end else if (waddr_r[7:2] == STAT_ADDR[7:2]) begin
        bresp_nxt = RESP_OKAY;
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      if (araddr[7:2] == DEV_ADDR[7:2]) begin
        rdata_nxt = {24'h000000, dev_r};
      end else if (araddr[7:2] == LOCK_ADDR[7:2]) begin
        rdata_nxt = {24'h000000, lock_r};
      end else if (araddr[7:2] == ANA_ADDR[7:2]) begin
        rdata_nxt = {24'h000000, ana_r};
      end else if (araddr[7:2] == CLKDIV_ADDR[7:2]) begin
        rdata_nxt = {16'h0000, clkdiv_r};
      end else if (araddr[7:2] == STAT_ADDR[7:2]) begin
        rdata_nxt = status_word;
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = RESP_SLVERR;
      end
    end
    awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_got_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // Register bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_r     <= DEV_RST;
      lock_r    <= LOCK_RST;
      ana_r     <= ANA_RST;
      clkdiv_r  <= CLKDIV_RST;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= 8'h00;
      wdat_r    <= 32'h00000000;
      wstb_r    <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end else begin
      dev_r     <= dev_nxt;
      lock_r    <= lock_nxt;
      ana_r     <= ana_nxt;
      clkdiv_r  <= clkdiv_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      waddr_r   <= waddr_nxt;
      wdat_r    <= wdat_nxt;
      wstb_r    <= wstb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [5:0] sync1_r, sync2_r, prev_r;
  logic       pre_tick, ref_evt, div_evt;

  // Two-flop synchroniser plus history flop for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      prev_r  <= 6'h00;
    end else begin
      sync1_r <= {cal_done_pin, osc_cal_cmp_pin, ds_divider_clock_pin,
                  div_cmp_pin, ref_cmp_pin, prescaler_clk_pin};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign pre_tick = sync2_r[0] & ~prev_r[0];
  assign ref_evt  = sync2_r[1] & ~prev_r[1];
  assign div_evt  = sync2_r[2] & ~prev_r[2];

  // ****************************************************************
  // Lock detector
  // ****************************************************************
  logic [2:0] win_len;
  logic [9:0] lk_thr, ul_thr;

  assign win_len = lock_r[WIN_BIT] ? WIN_WIDE : WIN_NARROW;
  assign lk_thr  = thr_lock(lock_r[THR_HI:THR_LO]);
  assign ul_thr  = thr_unlock(lock_r[THR_HI:THR_LO]);

  // Gap measurement between the two phase edges, then counting
  always_comb begin
    meas_nxt   = meas_r;
    gap_nxt    = gap_r;
    cmp_done   = 1'b0;
    in_win     = 1'b0;
    cnt_nxt    = cnt_r;
    locked_nxt = locked_r;
    mom_nxt    = mom_r;
    case (meas_r)
      MEAS_IDLE: begin
        gap_nxt = 3'h0;
        if (ref_evt && div_evt) begin
          cmp_done = 1'b1;
          in_win   = 1'b1;
        end else if (ref_evt || div_evt) begin
          meas_nxt = MEAS_RUN;
        end
      end
      MEAS_RUN: begin
        if (ref_evt || div_evt) begin
          cmp_done = 1'b1;
          in_win   = (gap_r < win_len);
          meas_nxt = MEAS_IDLE;
        end else if (pre_tick && gap_r != GAP_MAX) begin
          gap_nxt = gap_r + 3'h1;
        end
      end
      default: meas_nxt = MEAS_IDLE;
    endcase
    if (cmp_done) begin
      mom_nxt = in_win;
      if (in_win) begin
        if (cnt_r != CNT_MAX) cnt_nxt = cnt_r + 10'h001;
      end else if (!lock_r[MODE_BIT]) begin
        cnt_nxt = 10'h000;
      end else if (cnt_r != 10'h000) begin
        cnt_nxt = cnt_r - 10'h001;
      end
      if (locked_r) locked_nxt = (cnt_nxt > ul_thr);
      else locked_nxt = (cnt_nxt >= lk_thr);
    end
  end

  // Lock detector flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_r   <= MEAS_IDLE;
      gap_r    <= 3'h0;
      cnt_r    <= 10'h000;
      locked_r <= 1'b0;
      mom_r    <= 1'b0;
    end else begin
      meas_r   <= meas_nxt;
      gap_r    <= gap_nxt;
      cnt_r    <= cnt_nxt;
      locked_r <= locked_nxt;
      mom_r    <= mom_nxt;
    end
  end

  // ****************************************************************
  // Reference, symbol and baud dividers
  // ****************************************************************
  logic [2:0]  ref_cnt_r, ref_cnt_nxt, ref_last;
  logic [10:0] sym_cnt_r, sym_cnt_nxt, sym_last;
  logic [2:0]  baud_cnt_r, baud_cnt_nxt;
  logic        ref_tick_r, ref_tick_nxt, sym_tick_r, sym_tick_nxt;
  logic        baud_tick_r, baud_tick_nxt;
  logic        xtal_tgl_r, ref_tgl_r, sym_tgl_r;
  logic [10:0] div_prod;

  // Code zero is unsupported and falls back to the divide-by-two count
  assign ref_last = (clkdiv_r[REFD_HI:REFD_LO] == 3'h0) ? 3'h1 : clkdiv_r[REFD_HI:REFD_LO];
  assign div_prod = {3'h0, clkdiv_r[DIV1_HI:DIV1_LO]} << clkdiv_r[DIV2_HI:DIV2_LO];
  assign sym_last = (div_prod == 11'h000) ? 11'h000 : div_prod - 11'h001;

  // Divider chain, each stage a one-cycle enable
  always_comb begin
    ref_cnt_nxt   = (ref_cnt_r >= ref_last) ? 3'h0 : ref_cnt_r + 3'h1;
    ref_tick_nxt  = (ref_cnt_r >= ref_last);
    sym_cnt_nxt   = sym_cnt_r;
    sym_tick_nxt  = 1'b0;
    baud_cnt_nxt  = baud_cnt_r;
    baud_tick_nxt = 1'b0;
    if (ref_tick_r) begin
      sym_tick_nxt = (sym_cnt_r >= sym_last);
      sym_cnt_nxt  = sym_tick_nxt ? 11'h000 : sym_cnt_r + 11'h001;
    end
    if (sym_tick_r) begin
      baud_tick_nxt = (baud_cnt_r == BAUD_LAST);
      baud_cnt_nxt  = baud_cnt_r + 3'h1;
    end
  end

  // Divider flops and square-wave toggles for the lock pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_r   <= 3'h0;
      sym_cnt_r   <= 11'h000;
      baud_cnt_r  <= 3'h0;
      ref_tick_r  <= 1'b0;
      sym_tick_r  <= 1'b0;
      baud_tick_r <= 1'b0;
      xtal_tgl_r  <= 1'b0;
      ref_tgl_r   <= 1'b0;
      sym_tgl_r   <= 1'b0;
    end else begin
      ref_cnt_r   <= ref_cnt_nxt;
      sym_cnt_r   <= sym_cnt_nxt;
      baud_cnt_r  <= baud_cnt_nxt;
      ref_tick_r  <= ref_tick_nxt;
      sym_tick_r  <= sym_tick_nxt;
      baud_tick_r <= baud_tick_nxt;
      xtal_tgl_r  <= ~xtal_tgl_r;
      ref_tgl_r   <= ref_tgl_r ^ ref_tick_r;
      sym_tgl_r   <= sym_tgl_r ^ sym_tick_r;
    end
  end

  assign ref_tick    = ref_tick_r;
  assign symbol_tick = sym_tick_r;
  assign baud_tick   = baud_tick_r;

  // ****************************************************************
  // Lock pin selector and modulation outputs
  // ****************************************************************
  logic        lock_pin_r, lock_pin_nxt, ook_r, ook_nxt;
  logic [10:0] dev_scaled_r, dev_scaled_nxt;
  logic [4:0]  dev_shift_r, dev_shift_nxt;

  // Output selection and deviation terms
  always_comb begin
    case (lock_r[SEL_HI:SEL_LO])
      SRC_ONE:   lock_pin_nxt = 1'b1;
      SRC_SUST:  lock_pin_nxt = ~locked_r;
      SRC_MOM:   lock_pin_nxt = ~mom_r;
      SRC_CAL:   lock_pin_nxt = ~sync2_r[5];
      SRC_XTAL:  lock_pin_nxt = xtal_tgl_r;
      SRC_REF:   lock_pin_nxt = ref_tgl_r;
      SRC_PRE:   lock_pin_nxt = sync2_r[0];
      SRC_DS:    lock_pin_nxt = sync2_r[3];
      SRC_SYM:   lock_pin_nxt = sym_tgl_r;
      SRC_OSC:   lock_pin_nxt = sync2_r[4];
      SRC_PHASE: lock_pin_nxt = sync2_r[1];
      default:   lock_pin_nxt = 1'b0;
    endcase
    ook_nxt        = (dev_r[MANT_HI:MANT_LO] == 4'h0);
    dev_scaled_nxt = {7'h00, dev_r[MANT_HI:MANT_LO]} << dev_r[EXP_HI:EXP_LO];
    dev_shift_nxt  = ana_r[BAND_BIT] ? SHIFT_HIGH : SHIFT_LOW;
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_pin_r   <= 1'b0;
      ook_r        <= 1'b0;
      dev_scaled_r <= 11'h000;
      dev_shift_r  <= SHIFT_HIGH;
    end else begin
      lock_pin_r   <= lock_pin_nxt;
      ook_r        <= ook_nxt;
      dev_scaled_r <= dev_scaled_nxt;
      dev_shift_r  <= dev_shift_nxt;
    end
  end

  assign lock_pin            = lock_pin_r;
  assign ook_mode            = ook_r;
  assign dev_scaled          = dev_scaled_r;
  assign dev_shift           = dev_shift_r;
  assign gauss_shape_en      = dev_r[GAUSS_BIT];
  assign band_choice         = ana_r[BAND_BIT];
  assign detector_delay_long = ana_r[PDL_BIT];
  assign amp_bias_extra      = ana_r[BOOST_BIT];
  assign divider_buffer_bias = ana_r[BIAS_HI:BIAS_LO];

  // ****************************************************************
  // Checks
  // ****************************************************************
  ook_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (ook_mode == ($past(dev_r[MANT_HI:MANT_LO]) == 4'h0)))
    else $error("ook mode does not follow mantissa");
  band_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $past(band_choice) |-> dev_shift == 5'h0F)
    else $error("upper band shift wrong");
  low_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && !$past(band_choice) |-> dev_shift == 5'h10)
    else $error("lower band shift wrong");
  pin_const_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_r[SEL_HI:SEL_LO] == 4'h1 ##1 lock_r[SEL_HI:SEL_LO] == 4'h1 |-> lock_pin)
    else $error("lock pin constant one wrong");
  pin_sust_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_r[SEL_HI:SEL_LO] == 4'h2 |=> lock_pin == !$past(locked_r))
    else $error("lock pin sustained lock wrong");
  cnt_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done && !in_win && !lock_r[MODE_BIT] |=> cnt_r == 10'h000)
    else $error("restart mode did not clear counter");
  cnt_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done && !in_win && lock_r[MODE_BIT] && cnt_r != 10'h000
      |=> cnt_r == $past(cnt_r) - 10'h001)
    else $error("up/down mode did not decrement");
  lock_declare_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done && !locked_r && cnt_nxt >= thr_lock(lock_r[THR_HI:THR_LO]) |=> locked_r)
    else $error("lock not declared at threshold");
  win_narrow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done && meas_r == MEAS_RUN && !lock_r[WIN_BIT] && gap_r >= 3'h2 |-> !in_win)
    else $error("narrow window accepted wide gap");
  reg_reset_a: assert property (@(posedge aclk)
    !aresetn |=> dev_r == 8'hE8 && lock_r == 8'h00 && ana_r == 8'h83)
    else $error("register reset value wrong");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_got_r && w_got_r && !bvalid_r |=> bvalid)
    else $error("write response not raised");
  resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before accept");

endmodule

// file: cmp_pin_host.sv
`timescale 1ns/10ps
module cmp_pin_host (
  input  wire logic aclk,
  input  wire logic en,
  input  wire logic in_win,
  output logic      prescaler_clk_pin,
  output logic      ref_cmp_pin,
  output logic      div_cmp_pin
);
  logic [4:0] phase_r;

  // ****************************************************************
  // Compare pulses every 32 cycles, all pins low while idle
  // ****************************************************************
  always_ff @(posedge aclk) begin
    phase_r <= en ? phase_r + 5'h01 : 5'h00;
    prescaler_clk_pin <= en & ~prescaler_clk_pin;
    ref_cmp_pin <= en & (phase_r < 5'h02);
    div_cmp_pin <= en & ((in_win ? phase_r : phase_r - 5'h10) < 5'h02);
  end
endmodule

// file: tx_deviation_lock_config_bench.sv
`timescale 1ns/10ps
module tx_deviation_lock_config_bench
  import tx_dev_lock_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic        arready, rvalid, rready, prescaler_clk_pin, ref_cmp_pin, div_cmp_pin;
  logic        ds_divider_clock_pin, osc_cal_cmp_pin, cal_done_pin, lock_pin, gauss_shape_en, ook_mode;
  logic        band_choice, detector_delay_long, amp_bias_extra, ref_tick, symbol_tick;
  logic        baud_tick, en, in_win;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, divider_buffer_bias, resp;
  logic [10:0] dev_scaled;
  logic [4:0]  dev_shift;
  logic [3:0]  src [10] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h9, 4'hA, 4'h5, 4'hC, 4'hE, 4'h2};
  int          n_errors, compares;

  tx_deviation_lock_config DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .prescaler_clk_pin(prescaler_clk_pin),
    .ref_cmp_pin(ref_cmp_pin), .div_cmp_pin(div_cmp_pin), .ds_divider_clock_pin(ds_divider_clock_pin),
    .osc_cal_cmp_pin(osc_cal_cmp_pin), .cal_done_pin(cal_done_pin), .lock_pin(lock_pin),
    .gauss_shape_en(gauss_shape_en), .ook_mode(ook_mode), .dev_scaled(dev_scaled),
    .dev_shift(dev_shift), .band_choice(band_choice),
    .detector_delay_long(detector_delay_long), .amp_bias_extra(amp_bias_extra),
    .divider_buffer_bias(divider_buffer_bias), .ref_tick(ref_tick),
    .symbol_tick(symbol_tick), .baud_tick(baud_tick)
  );
  cmp_pin_host host (
    .aclk(aclk), .en(en), .in_win(in_win), .prescaler_clk_pin(prescaler_clk_pin),
    .ref_cmp_pin(ref_cmp_pin), .div_cmp_pin(div_cmp_pin)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test(input bit hung);
    if (hung)
      n_errors++;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    resp = bresp;
    if (n >= 40) stop_test(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    araddr  <= a;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    resp = rresp;
    chk(rdata, e);
    if (n >= 40) stop_test(1);
  endtask

  // Exactly k compare periods, then quiet pins
  task automatic burst(input int k, input logic w);
    in_win <= w;
    en     <= 1'b1;
    repeat (k * 32) @(posedge aclk);
    en <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  // Count divider enables over a window of n cycles
  task automatic tick_count(input int n, input logic [31:0] er, es, eb);
    logic [31:0] nr, ns, nb;
    nr = 0;
    ns = 0;
    nb = 0;
    repeat (16) @(posedge aclk);
    repeat (n) begin
      @(posedge aclk);
      nr = nr + ref_tick;
      ns = ns + symbol_tick;
      nb = nb + baud_tick;
    end
    chk(nr, er);
    chk(ns, es);
    chk(nb, eb);
  endtask

  // ****************************************************************
  // Clock and test sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, en, in_win} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {ds_divider_clock_pin, osc_cal_cmp_pin, cal_done_pin} = 3'b101;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    rd_chk(DEV_ADDR, 32'h000000E8);
    rd_chk(LOCK_ADDR, 32'h00000000);
    rd_chk(ANA_ADDR, 32'h00000083);
    chk({gauss_shape_en, dev_scaled, dev_shift}, 17'h1400F);
    $display("test reset done");
    wr(DEV_ADDR, 32'h5A);
    wr(ANA_ADDR, 32'h17);
    settle;
    chk({gauss_shape_en, ook_mode, dev_scaled}, 13'h0140);
    chk(dev_shift, 5'h10);
    chk({detector_delay_long, amp_bias_extra, divider_buffer_bias}, 4'hF);
    wr(DEV_ADDR, 32'h30);
    wr(ANA_ADDR, 32'hE4);
    chk(resp, RESP_OKAY);
    settle;
    chk({ook_mode, dev_shift, band_choice}, 7'b1011111);
    rd_chk(ANA_ADDR, 32'h00000084);
    chk(resp, RESP_OKAY);
    wr(8'h60, 32'h1);
    chk(resp, RESP_SLVERR);
    rd_chk(8'h60, 32'h0);
    chk(resp, RESP_SLVERR);
    $display("test config done");
    tick_count(96, 32, 8, 1);
    wr(CLKDIV_ADDR, 32'h0161);
    rd_chk(CLKDIV_ADDR, 32'h00000161);
    tick_count(64, 16, 8, 1);
    $display("test divider done");
    foreach (src[i]) begin
      wr(LOCK_ADDR, {24'h0, src[i], 4'h0});
      settle;
      chk(lock_pin, src[i] inside {4'h1, 4'h2, 4'hC});
    end
    $display("test pin done");
    wr(LOCK_ADDR, 32'h20);
    burst(130, 1'b1);
    rd_chk(STAT_ADDR, 32'h00820003);
    chk(lock_pin, 1'b0);
    wr(LOCK_ADDR, 32'h24);
    burst(3, 1'b0);
    rd_chk(STAT_ADDR, 32'h007F0001);
    wr(LOCK_ADDR, 32'h25);
    burst(1, 1'b0);
    rd_chk(STAT_ADDR, 32'h007E0000);
    wr(LOCK_ADDR, 32'h20);
    burst(1, 1'b0);
    rd_chk(STAT_ADDR, 32'h00000000);
    chk(lock_pin, 1'b1);
    $display("test lock done");
    stop_test(0);
  end
endmodule
